// >>> sim/stao_core_tb_top.sv
// Self-checking testbench for the skip, subtract, swap, table and XOR executor.
`timescale 1ns/10ps
`default_nettype none
module stao_core_tb_top;
    import stao_pkg::*;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h00000000;
    logic [15:0] prog_data_in = 16'h0000;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic prog_rd_out;
    logic [15:0] prog_addr_out;
    logic skip_out;
    logic busy_out;
    logic [31:0] rd;
    logic err;
    logic [15:0] last_pa;
    int n_errors = 0;
    int n_checks = 0;
    int n_skip = 0;
    int n_busy = 0;

    stao_core DUT (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .prog_rd_out(prog_rd_out),
        .prog_addr_out(prog_addr_out), .prog_data_in(prog_data_in), .skip_out(skip_out), .busy_out(busy_out));

    // Free-running 125 MHz clock.
    always #4 mclk_in = ~mclk_in;

    // ----------------------------------------
    // Program memory and monitors
    // ----------------------------------------
    function automatic logic [15:0] rom(input logic [15:0] a);
        return {a[7:0] ^ 8'hA5, a[15:8] + 8'h3C};
    endfunction

    // One cycle of latency; outside a fetch the word toggles so a late sample cannot pass by luck.
    always @(posedge mclk_in) begin
        prog_data_in <= prog_rd_out ? rom(prog_addr_out) : ~prog_data_in;
    end

    // Count dummy and busy cycles and remember the last fetch address.
    always @(posedge mclk_in) begin
        if (skip_out === 1'b1) n_skip++;
        if (busy_out === 1'b1) n_busy++;
        if (prog_rd_out === 1'b1) last_pa = prog_addr_out;
    end

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; an idle edge follows so psel is never assigned twice in one step.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        @(posedge mclk_in);
        // Only the watchdog ends a wait for the answer.
        while (pready_out !== 1'b1) begin
            @(posedge mclk_in);
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge mclk_in);
    endtask

    // Load byte, working register and flags, run one opcode, then compare everything it may touch.
    task automatic t(input logic [4:0] op, input logic [2:0] b, input logic [7:0] lit, input logic [7:0] m0,
                     input logic [7:0] w0, input logic [5:0] f0, input int sk, input logic [5:0] f1,
                     input logic [7:0] m1, input logic [7:0] w1);
        apb(1'b1, REG_OPND, {16'h0000, lit, 8'h07});
        apb(1'b1, REG_DWIN, {24'h000000, m0});
        apb(1'b1, REG_WORK, {24'h000000, w0});
        apb(1'b1, REG_FLAGS, {26'h0000000, f0});
        n_skip = 0;
        n_busy = 0;
        apb(1'b1, REG_CMD, {21'h000000, b, 3'b000, op});
        apb(1'b0, REG_FLAGS, 32'h00000000);
        while (rd[STAT_BUSY] !== 1'b0) begin
            apb(1'b0, REG_FLAGS, 32'h00000000);
        end
        chk("flags", {26'h0000000, rd[5:0]}, {26'h0000000, f1});
        chk("skip flag", {31'h00000000, rd[STAT_SKIP]}, sk);
        chk("skip cycles", n_skip, sk);
        chk("busy cycles", n_busy, (op >= OP_TPF && op <= OP_TFB) ? 3 : 1 + sk);
        apb(1'b0, REG_DWIN, 32'h00000000);
        chk("memory", rd, {24'h000000, m1});
        apb(1'b0, REG_WORK, 32'h00000000);
        chk("work", rd, {24'h000000, w1});
    endtask

    // Table read with the expected word worked out from the bench's own program image.
    task automatic tab(input logic [4:0] op, input logic [7:0] lo, input logic [15:0] pa);
        logic [15:0] w;
        w = rom(pa);
        t(op, 3'h0, 8'h00, 8'hEE, 8'h55, 6'h2A, 0, 6'h2A, w[7:0], 8'h55);
        apb(1'b0, REG_TLATCH, 32'h00000000);
        chk("latch", rd, {24'h000000, w[15:8]});
        chk("fetch address", {16'h0000, last_pa}, {16'h0000, pa});
        apb(1'b0, REG_TPLO, 32'h00000000);
        chk("pointer low", rd, {24'h000000, lo});
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        @(posedge mclk_in);
        t(OP_DSM, 3'h0, 8'h00, 8'h01, 8'h55, 6'h2A, 1, 6'h2A, 8'h00, 8'h55);
        t(OP_DSM, 3'h0, 8'h00, 8'h00, 8'h55, 6'h2A, 0, 6'h2A, 8'hFF, 8'h55);
        t(OP_DSW, 3'h0, 8'h00, 8'h01, 8'h55, 6'h2A, 1, 6'h2A, 8'h01, 8'h00);
        t(OP_DSW, 3'h0, 8'h00, 8'h05, 8'h55, 6'h2A, 0, 6'h2A, 8'h05, 8'h04);
        t(OP_ISM, 3'h0, 8'h00, 8'hFF, 8'h55, 6'h2A, 1, 6'h2A, 8'h00, 8'h55);
        t(OP_ISM, 3'h0, 8'h00, 8'h41, 8'h55, 6'h2A, 0, 6'h2A, 8'h42, 8'h55);
        t(OP_ISW, 3'h0, 8'h00, 8'h07, 8'h55, 6'h2A, 0, 6'h2A, 8'h07, 8'h08);
        t(OP_ISW, 3'h0, 8'h00, 8'hFF, 8'h55, 6'h2A, 1, 6'h2A, 8'hFF, 8'h00);
        t(OP_SETB, 3'h0, 8'h00, 8'h12, 8'h55, 6'h2A, 0, 6'h2A, 8'hFF, 8'h55);
        t(OP_SETI, 3'h7, 8'h00, 8'h01, 8'h55, 6'h15, 0, 6'h15, 8'h81, 8'h55);
        t(OP_TNZB, 3'h7, 8'h00, 8'h81, 8'h55, 6'h2A, 1, 6'h2A, 8'h81, 8'h55);
        t(OP_TNZB, 3'h1, 8'h00, 8'h81, 8'h55, 6'h2A, 0, 6'h2A, 8'h81, 8'h55);
        t(OP_TZB, 3'h1, 8'h00, 8'h81, 8'h55, 6'h2A, 1, 6'h2A, 8'h81, 8'h55);
        t(OP_TZB, 3'h0, 8'h00, 8'h81, 8'h55, 6'h2A, 0, 6'h2A, 8'h81, 8'h55);
        t(OP_TNZ, 3'h0, 8'h00, 8'h80, 8'h55, 6'h2A, 1, 6'h2A, 8'h80, 8'h55);
        t(OP_TNZ, 3'h0, 8'h00, 8'h00, 8'h55, 6'h2A, 0, 6'h2A, 8'h00, 8'h55);
        t(OP_TZ, 3'h0, 8'h00, 8'h00, 8'h55, 6'h2A, 1, 6'h2A, 8'h00, 8'h55);
        t(OP_TZ, 3'h0, 8'h00, 8'h40, 8'h55, 6'h2A, 0, 6'h2A, 8'h40, 8'h55);
        t(OP_TZM, 3'h0, 8'h00, 8'h00, 8'h55, 6'h2A, 1, 6'h2A, 8'h00, 8'h00);
        t(OP_TZM, 3'h0, 8'h00, 8'h33, 8'h55, 6'h2A, 0, 6'h2A, 8'h33, 8'h33);
        t(OP_SUB, 3'h0, 8'h00, 8'h07, 8'h05, 6'h2A, 0, 6'h10, 8'h07, 8'hFE);
        t(OP_MINUS_TO_MEMORY, 3'h0, 8'h00, 8'h01, 8'h80, 6'h00, 0, 6'h19, 8'h7F, 8'h80);
        t(OP_SUBL, 3'h0, 8'h10, 8'h99, 8'h10, 6'h00, 0, 6'h27, 8'h99, 8'h00);
        t(OP_SWP, 3'h0, 8'h00, 8'h3C, 8'h55, 6'h2A, 0, 6'h2A, 8'hC3, 8'h55);
        t(OP_SWPW, 3'h0, 8'h00, 8'h12, 8'h55, 6'h2A, 0, 6'h2A, 8'h12, 8'h21);
        t(OP_XOR, 3'h0, 8'h00, 8'hF0, 8'hF0, 6'h2A, 0, 6'h2E, 8'hF0, 8'h00);
        t(OP_EXCLUSIVE_OR_TO_MEMORY, 3'h0, 8'h00, 8'hF0, 8'hF0, 6'h2A, 0, 6'h2E, 8'h00, 8'hF0);
        t(OP_XORL, 3'h0, 8'h0F, 8'h99, 8'h3C, 6'h2E, 0, 6'h2A, 8'h99, 8'h33);
        apb(1'b1, REG_TPHI, 32'h00000012);
        apb(1'b1, REG_TPLO, 32'h00000034);
        tab(OP_TPF, 8'h34, 16'h1234);
        tab(OP_TFF, 8'h34, 16'hFF34);
        tab(OP_TPB, 8'h35, 16'h1235);
        tab(OP_TFB, 8'h36, 16'hFF36);
        apb(1'b0, 8'h20, 32'h00000000);
        chk("unmapped error", {31'h00000000, err}, 32'h00000001);
        give_verdict();
    end

    // Watchdog: the sequence needs well under 5000 cycles.
    initial begin
        #100000;
        n_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> src/stao_core.sv
// Executor for skip, subtract, swap, table read and XOR instructions behind an APB slave.
`timescale 1ns/10ps
`default_nettype none
module stao_core
    import stao_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic prog_rd_out,
    output logic [15:0] prog_addr_out,
    input wire logic [15:0] prog_data_in,
    output logic skip_out,
    output logic busy_out
);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // Subtract a minus b; returns {cz, sc, ov, z, ac, c, result}.
    function automatic logic [13:0] sub8(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] d;
        logic [4:0] dl;
        logic ov, z;
        d = {1'b0, a} - {1'b0, b};
        dl = {1'b0, a[3:0]} - {1'b0, b[3:0]};
        ov = (a[7] ^ b[7]) & (a[7] ^ d[7]);
        z = (d[7:0] == 8'h00);
        // No chained-borrow input here, so the chained flag follows zero.
        sub8 = {z, ov ^ d[7], ov, z, ~dl[4], ~d[8], d[7:0]};
    endfunction

    // Exchange the two nibbles of a byte.
    function automatic logic [7:0] swap_nib(input logic [7:0] v);
        swap_nib = {v[3:0], v[7:4]};
    endfunction

    // ----------------------------------------
    // State and storage
    // ----------------------------------------

    stao_state_t st_q, st_d;
    logic [7:0] dmem [DMEM_DEPTH];
    logic [4:0] op_q;
    logic [2:0] bsel_q;
    logic [DMEM_AW-1:0] addr_q;
    logic [7:0] lit_q, work_q, table_pointer_low_q, table_pointer_high_q, tlatch_q;
    logic [5:0] flags_q;
    logic [15:0] taddr_q;
    logic skip_q;
    logic [31:0] prdata_q;

    logic [7:0] mem_rd, res;
    logic [5:0] flags_n;
    logic [13:0] sres;
    logic bit_val, wr_mem, wr_work, skip, tab, bump, final_pg, exec, apb_wr, apb_set, mapped;

    assign mem_rd = dmem[addr_q];
    assign bit_val = mem_rd[bsel_q];
    assign exec = (st_q == ST_EXEC);

    // ----------------------------------------
    // Operation decode and datapath
    // ----------------------------------------

    // One cycle of combinational work per instruction; all results except the table word, written in TCAP, land at the end of EXEC.
    always_comb begin
        res = 8'h00;
        flags_n = flags_q;
        wr_mem = 1'b0;
        wr_work = 1'b0;
        skip = 1'b0;
        tab = 1'b0;
        bump = 1'b0;
        final_pg = 1'b0;
        sres = 14'h0000;
        case (op_q)
            OP_DSM, OP_DSW: begin
                res = mem_rd - ONE_8;
                wr_mem = (op_q == OP_DSM);
                wr_work = (op_q == OP_DSW);
                skip = (res == 8'h00);
            end
            OP_SETB: begin
                res = BYTE_ONES;
                wr_mem = 1'b1;
            end
            OP_SETI: begin
                res = mem_rd | (ONE_8 << bsel_q);
                wr_mem = 1'b1;
            end
            OP_ISM, OP_ISW: begin
                res = mem_rd + ONE_8;
                wr_mem = (op_q == OP_ISM);
                wr_work = (op_q == OP_ISW);
                skip = (res == 8'h00);
            end
            OP_TNZB: begin
                skip = bit_val;
            end
            OP_TNZ: begin
                res = mem_rd;
                wr_mem = 1'b1;
                skip = (mem_rd != 8'h00);
            end
            OP_SUB, OP_MINUS_TO_MEMORY, OP_SUBL: begin
                // Immediate form takes the literal, others the data byte.
                sres = sub8(work_q, (op_q == OP_SUBL) ? lit_q : mem_rd);
                res = sres[7:0];
                flags_n = sres[13:8];
                wr_mem = (op_q == OP_MINUS_TO_MEMORY);
                wr_work = (op_q != OP_MINUS_TO_MEMORY);
            end
            OP_SWP: begin
                res = swap_nib(mem_rd);
                wr_mem = 1'b1;
            end
            OP_SWPW: begin
                res = swap_nib(mem_rd);
                wr_work = 1'b1;
            end
            OP_TZ: begin
                res = mem_rd;
                wr_mem = 1'b1;
                skip = (mem_rd == 8'h00);
            end
            OP_TZM: begin
                res = mem_rd;
                wr_work = 1'b1;
                skip = (mem_rd == 8'h00);
            end
            OP_TZB: begin
                skip = ~bit_val;
            end
            OP_TPF, OP_TFF, OP_TPB, OP_TFB: begin
                tab = 1'b1;
                final_pg = (op_q == OP_TFF) || (op_q == OP_TFB);
                bump = (op_q == OP_TPB) || (op_q == OP_TFB);
            end
            OP_XOR, OP_EXCLUSIVE_OR_TO_MEMORY, OP_XORL: begin
                res = work_q ^ ((op_q == OP_XORL) ? lit_q : mem_rd);
                flags_n[FLAG_Z] = (res == 8'h00);
                wr_mem = (op_q == OP_EXCLUSIVE_OR_TO_MEMORY);
                wr_work = (op_q != OP_EXCLUSIVE_OR_TO_MEMORY);
            end
            default: begin
                res = 8'h00;
            end
        endcase
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------

    // A taken skip spends one extra cycle doing nothing, standing for the discarded fetch.
    always_comb begin
        case (st_q)
            ST_IDLE: st_d = ST_IDLE;
            ST_EXEC: st_d = tab ? ST_TREQ : (skip ? ST_DUMMY : ST_IDLE);
            ST_DUMMY: st_d = ST_IDLE;
            ST_TREQ: st_d = ST_TCAP;
            ST_TCAP: st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end

    // Commands are only taken while idle, so a running instruction is never disturbed.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q <= ST_IDLE;
        end else if (st_q == ST_IDLE && apb_wr && paddr_in == REG_CMD) begin
            st_q <= ST_EXEC;
        end else begin
            st_q <= st_d;
        end
    end

    // Skip outcome of the last finished instruction, held for software.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            skip_q <= 1'b0;
        end else if (exec) begin
            skip_q <= skip;
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------

    assign apb_wr = psel_in && penable_in && pwrite_in;
    assign apb_set = apb_wr && (st_q == ST_IDLE);
    assign mapped = (paddr_in[7:5] == 3'b000) && (paddr_in[1:0] == 2'b00);
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;
    assign prdata_out = prdata_q;
    assign busy_out = (st_q != ST_IDLE);
    assign skip_out = (st_q == ST_DUMMY);
    assign prog_rd_out = (st_q == ST_TREQ);
    assign prog_addr_out = taddr_q;

    // Read data is captured in the setup phase so the access phase can end at once.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel_in && !penable_in) begin
            case (paddr_in)
                REG_CMD: prdata_q <= {21'h000000, bsel_q, 3'h0, op_q};
                REG_OPND: prdata_q <= {16'h0000, lit_q, 3'h0, addr_q};
                REG_WORK: prdata_q <= {24'h000000, work_q};
                REG_FLAGS: prdata_q <= {22'h000000, busy_out, skip_q, 2'h0, flags_q};
                REG_TPLO: prdata_q <= {24'h000000, table_pointer_low_q};
                REG_TPHI: prdata_q <= {24'h000000, table_pointer_high_q};
                REG_TLATCH: prdata_q <= {24'h000000, tlatch_q};
                REG_DWIN: prdata_q <= {24'h000000, mem_rd};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Command and operand registers.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            op_q <= 5'h00;
            bsel_q <= 3'h0;
            addr_q <= '0;
            lit_q <= 8'h00;
        end else if (apb_set && paddr_in == REG_CMD) begin
            op_q <= pwdata_in[4:0];
            bsel_q <= pwdata_in[CMD_BIT_LSB +: 3];
        end else if (apb_set && paddr_in == REG_OPND) begin
            addr_q <= pwdata_in[DMEM_AW-1:0];
            lit_q <= pwdata_in[OPND_LIT_LSB +: 8];
        end
    end

    // ----------------------------------------
    // Architectural registers
    // ----------------------------------------

    // Working register: instruction results win; software may load it only while idle.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            work_q <= WORK_RST;
        end else if (exec && wr_work) begin
            work_q <= res;
        end else if (apb_set && paddr_in == REG_WORK) begin
            work_q <= pwdata_in[7:0];
        end
    end

    // Flags: only subtract and XOR forms produce new values in flags_n.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flags_q <= FLAGS_RST;
        end else if (exec) begin
            flags_q <= flags_n;
        end else if (apb_set && paddr_in == REG_FLAGS) begin
            flags_q <= pwdata_in[5:0];
        end
    end

    // Table pointer bytes; the low byte is bumped before the address is formed.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            table_pointer_low_q <= TP_RST;
            table_pointer_high_q <= TP_RST;
        end else if (exec && bump) begin
            table_pointer_low_q <= table_pointer_low_q + ONE_8;
        end else if (apb_set && paddr_in == REG_TPLO) begin
            table_pointer_low_q <= pwdata_in[7:0];
        end else if (apb_set && paddr_in == REG_TPHI) begin
            table_pointer_high_q <= pwdata_in[7:0];
        end
    end

    // Program memory address; the final page ignores the high pointer byte.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            taddr_q <= 16'h0000;
        end else if (exec && tab) begin
            taddr_q <= {final_pg ? LAST_PAGE : table_pointer_high_q, bump ? table_pointer_low_q + ONE_8 : table_pointer_low_q};
        end
    end

    // High byte of the fetched word, readable by software.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tlatch_q <= 8'h00;
        end else if (st_q == ST_TCAP) begin
            tlatch_q <= prog_data_in[15:8];
        end
    end

    // Data memory; no reset because it models plain RAM contents.
    always_ff @(posedge mclk_in) begin
        if (exec && wr_mem) begin
            dmem[addr_q] <= res;
        end else if (st_q == ST_TCAP) begin
            dmem[addr_q] <= prog_data_in[7:0];
        end else if (apb_set && paddr_in == REG_DWIN) begin
            dmem[addr_q] <= pwdata_in[7:0];
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    dec_skip_mem_a: assert property (exec && op_q == OP_DSM |=>
        mem_rd == $past(mem_rd) - ONE_8 && (st_q == ST_DUMMY) == ($past(mem_rd) == ONE_8))
        else $error("Decrement to memory or its skip went wrong.");
    dec_skip_work_a: assert property (exec && op_q == OP_DSW |=>
        work_q == $past(mem_rd) - ONE_8 && mem_rd == $past(mem_rd))
        else $error("Decrement to working register went wrong.");
    // Outside table reads, a taken skip costs exactly one dummy cycle before idle; an untaken one returns to idle at once.
    skip_timing_a: assert property (exec && !tab |=>
        if (skip_q) (st_q == ST_DUMMY ##1 st_q == ST_IDLE) else (st_q == ST_IDLE))
        else $error("Skip did not cost exactly one dummy cycle.");
    byte_set_a: assert property (exec && op_q == OP_SETB |=>
        mem_rd == BYTE_ONES && $stable(flags_q))
        else $error("Byte set wrong or flags moved.");
    bit_set_a: assert property (exec && op_q == OP_SETI |=>
        mem_rd == ($past(mem_rd) | (ONE_8 << $past(bsel_q))) && $stable(flags_q))
        else $error("Bit set touched other bits or flags.");
    inc_skip_a: assert property (exec && op_q == OP_ISM |=>
        mem_rd == $past(mem_rd) + ONE_8 && skip_q == ($past(mem_rd) == BYTE_ONES))
        else $error("Increment to memory or its wrap skip went wrong.");
    bit_tests_a: assert property (exec && (op_q == OP_TNZB || op_q == OP_TZB) |=>
        skip_q == ($past(bit_val) ^ ($past(op_q) == OP_TZB)) && $stable(flags_q))
        else $error("Bit test skip decision wrong.");
    sub_carry_a: assert property (exec && (op_q == OP_SUB || op_q == OP_MINUS_TO_MEMORY) |=>
        flags_q[FLAG_C] == ($past(work_q) >= $past(mem_rd)))
        else $error("Subtract carry does not reflect borrow.");
    swap_mem_a: assert property (exec && op_q == OP_SWP |=>
        mem_rd == {$past(mem_rd[3:0]), $past(mem_rd[7:4])} && $stable(flags_q))
        else $error("Nibble swap in place went wrong.");
    table_cap_a: assert property (st_q == ST_TCAP |=>
        mem_rd == $past(prog_data_in[7:0]) && tlatch_q == $past(prog_data_in[15:8]))
        else $error("Table word not split into byte and latch.");
    table_bump_a: assert property (exec && bump |=>
        table_pointer_low_q == $past(table_pointer_low_q) + ONE_8 && prog_rd_out && prog_addr_out[7:0] == table_pointer_low_q)
        else $error("Pointer bump or fetch address wrong.");
    xor_flags_a: assert property (exec && op_q == OP_XOR |=>
        work_q == ($past(work_q) ^ $past(mem_rd)) && flags_q[1:0] == $past(flags_q[1:0]))
        else $error("XOR result wrong or extra flags changed.");

endmodule
`default_nettype wire

// >>> src/stao_pkg.sv
// Constants, opcodes and types shared by the skip, subtract, swap, table and XOR executor.
package stao_pkg;
    localparam int DMEM_AW = 5;
    localparam int DMEM_DEPTH = 32;
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_OPND = 8'h04;
    localparam logic [7:0] REG_WORK = 8'h08;
    localparam logic [7:0] REG_FLAGS = 8'h0C;
    localparam logic [7:0] REG_TPLO = 8'h10;
    localparam logic [7:0] REG_TPHI = 8'h14;
    localparam logic [7:0] REG_TLATCH = 8'h18;
    localparam logic [7:0] REG_DWIN = 8'h1C;
    localparam int CMD_BIT_LSB = 8;
    localparam int OPND_LIT_LSB = 8;
    localparam int FLAG_C = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_SC = 4;
    localparam int FLAG_CZ = 5;
    localparam int STAT_SKIP = 8;
    localparam int STAT_BUSY = 9;
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic [7:0] TP_RST = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [7:0] LAST_PAGE = 8'hFF;
    localparam logic [7:0] ONE_8 = 8'h01;
    localparam logic [4:0] OP_DSM = 5'h00; // dec_skip_mem
    localparam logic [4:0] OP_DSW = 5'h01; // dec_skip_to_work
    localparam logic [4:0] OP_SETB = 5'h02;
    localparam logic [4:0] OP_SETI = 5'h03;
    localparam logic [4:0] OP_ISM = 5'h04; // inc_skip_mem
    localparam logic [4:0] OP_ISW = 5'h05; // inc_skip_to_work
    localparam logic [4:0] OP_TNZB = 5'h06;
    localparam logic [4:0] OP_TNZ = 5'h07; // test_nonzero_skip
    localparam logic [4:0] OP_SUB = 5'h08;
    localparam logic [4:0] OP_MINUS_TO_MEMORY = 5'h09; // minus_to_memory
    localparam logic [4:0] OP_SUBL = 5'h0A;
    localparam logic [4:0] OP_SWP = 5'h0B;
    localparam logic [4:0] OP_SWPW = 5'h0C; // nibble_exchange_to_work
    localparam logic [4:0] OP_TZ = 5'h0D; // test_null_skip
    localparam logic [4:0] OP_TZM = 5'h0E; // test_null_move_skip
    localparam logic [4:0] OP_TZB = 5'h0F;
    localparam logic [4:0] OP_TPF = 5'h10; // paged_table_fetch
    localparam logic [4:0] OP_TFF = 5'h11; // final_page_table_fetch
    localparam logic [4:0] OP_TPB = 5'h12; // bumped_paged_table_fetch
    localparam logic [4:0] OP_TFB = 5'h13; // bumped_final_page_fetch
    localparam logic [4:0] OP_XOR = 5'h14;
    localparam logic [4:0] OP_EXCLUSIVE_OR_TO_MEMORY = 5'h15; // exclusive_or_to_memory
    localparam logic [4:0] OP_XORL = 5'h16;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_EXEC = 3'b001,
        ST_DUMMY = 3'b010,
        ST_TREQ = 3'b011,
        ST_TCAP = 3'b100
    } stao_state_t;
endpackage
